// file: core/bcdc_top.sv
// bcdc_top: configuration and status of the internal clock source unit:
// bus divider, external oscillator controls, mode machine, ready flag.
// assumes a classic wishbone master and tick pulses from the clock sources.
// assumes every input is synchronous to clk_sys; no synchronisers here.
// limitation: the block only steers ticks, it never makes a clock itself.
`timescale 1ns/1ps
`default_nettype none
module bcdc_top #(
  parameter int OSC_STARTUP = bcdc_pkg::OSC_STARTUP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // clock source ticks
  input  wire logic        loop_tick,      // loop output edge
  input  wire logic        int_ref_tick,   // internal reference edge
  input  wire logic        ext_ref_tick,   // external reference edge
  input  wire logic        background_debug_mode,
  input  wire logic        stop_req,       // enter stop mode
  // outputs
  output logic             bus_tick,
  output logic             ext_ref_clock_out,
  output logic             osc_request,
  output logic             osc_high_range,
  output logic             osc_high_gain,
  output logic             loop_enable,
  output logic             fine_trim_bit,
  output logic [1:0]       clock_source_select,
  output logic [2:0]       mode_state,
  output logic             irq
);
  initial begin
    if (OSC_STARTUP < 1) $error("bcdc_top: OSC_STARTUP below 1");
  end

  // registers
  logic [7:0]          ctrl_two;     // clock_control_two
  logic [1:0]          mode_req;     // requested full power mode
  logic [bcdc_pkg::EV_W-1:0] irq_status; // sticky events
  logic [bcdc_pkg::EV_W-1:0] irq_mask;   // enables
  bcdc_pkg::bcdc_mode_t mode;        // current mode
  bcdc_pkg::bcdc_mode_t next_mode;   // mode for next cycle
  logic                osc_ready;    // oscillator_ready_flag
  logic                osc_ready_d;  // for rising edge event
  logic                wr_stb;       // write taken this cycle
  logic                rd_stb;       // read taken this cycle
  logic                drop;         // enable or select bit cleared
  logic                src_tick;     // selected clock edge
  logic                lowpwr_ok;    // low power gating allowed
  logic                ext_sel;      // external reference in use

  // single-cycle answer: request held, ack rises the cycle after
  assign wr_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;

  // ack pulses one cycle per request, drops after the taken edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // clock_control_two; divide by two out of reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_two <= bcdc_pkg::RST_CTRL_TWO;
    end else if (wr_stb && wb_adr_i == bcdc_pkg::OFS_CTRL_TWO) begin
      ctrl_two <= {wb_dat_i[7:1], 1'b0}; // bit 0 not used here
    end
  end

  // fine trim is the only writable bit of the status/trim register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fine_trim_bit <= 1'b0;
    end else if (wr_stb && wb_adr_i == bcdc_pkg::OFS_STATUS_TRIM) begin
      fine_trim_bit <= wb_dat_i[bcdc_pkg::TRIM_B];
    end
  end

  // requested mode and mask
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode_req <= bcdc_pkg::RST_MODE_REQ;
      irq_mask <= bcdc_pkg::RST_IRQ_MASK;
    end else if (wr_stb) begin
      if (wb_adr_i == bcdc_pkg::OFS_MODE_REQ) begin
        mode_req <= wb_dat_i[1:0];
      end
      if (wb_adr_i == bcdc_pkg::OFS_IRQ_MASK) begin
        irq_mask <= wb_dat_i[bcdc_pkg::EV_W-1:0];
      end
    end
  end

  // low power variants only while debug is not active
  // debug needs the loop, so it overrides the low power bit
  assign lowpwr_ok = ctrl_two[bcdc_pkg::LOWPWR_B] && !background_debug_mode;

  // mode machine; stop always returns to engaged internal
  // hazard: unless stop is asked, a low power mode falls back to its full power bypass mode
  // first, so the loop is running again before anything engages it
  always_comb begin
    next_mode = mode;
    case (mode)
      bcdc_pkg::BCDC_STOP: begin
        // leave stop only when the request is gone
        if (!stop_req) next_mode = bcdc_pkg::BCDC_ENG_INT;
      end
      bcdc_pkg::BCDC_BYP_INT_LOW: begin
        // debug or a new request wakes the loop
        if (!lowpwr_ok || mode_req != bcdc_pkg::REQ_BYP_INT) next_mode = bcdc_pkg::BCDC_BYP_INT;
      end
      bcdc_pkg::BCDC_BYP_EXT_LOW: begin
        // debug or a new request wakes the loop
        if (!lowpwr_ok || mode_req != bcdc_pkg::REQ_BYP_EXT) next_mode = bcdc_pkg::BCDC_BYP_EXT;
      end
      default: begin
        // full power modes move freely among themselves
        case (mode_req)
          bcdc_pkg::REQ_ENG_INT: next_mode = bcdc_pkg::BCDC_ENG_INT;
          bcdc_pkg::REQ_ENG_EXT: next_mode = bcdc_pkg::BCDC_ENG_EXT;
          bcdc_pkg::REQ_BYP_INT: next_mode = bcdc_pkg::BCDC_BYP_INT;
          default:               next_mode = bcdc_pkg::BCDC_BYP_EXT;
        endcase
        // low power only from its own bypass mode, one step at a time
        if (mode == bcdc_pkg::BCDC_BYP_INT && next_mode == bcdc_pkg::BCDC_BYP_INT && lowpwr_ok) begin
          next_mode = bcdc_pkg::BCDC_BYP_INT_LOW;
        end
        if (mode == bcdc_pkg::BCDC_BYP_EXT && next_mode == bcdc_pkg::BCDC_BYP_EXT && lowpwr_ok) begin
          next_mode = bcdc_pkg::BCDC_BYP_EXT_LOW;
        end
      end
    endcase
    // stop wins over every other request
    if (stop_req) next_mode = bcdc_pkg::BCDC_STOP;
  end

  // mode register starts in engaged internal
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode <= bcdc_pkg::BCDC_ENG_INT;
    end else begin
      mode <= next_mode;
    end
  end
  assign mode_state = mode;

  // clock source follows the mode
  always_comb begin
    case (mode)
      bcdc_pkg::BCDC_BYP_INT, bcdc_pkg::BCDC_BYP_INT_LOW: clock_source_select = bcdc_pkg::CSRC_INT;
      bcdc_pkg::BCDC_BYP_EXT, bcdc_pkg::BCDC_BYP_EXT_LOW: clock_source_select = bcdc_pkg::CSRC_EXT;
      default:                                            clock_source_select = bcdc_pkg::CSRC_LOOP;
    endcase
  end

  // the loop stops in low power bypass and in stop
  assign loop_enable = !(mode == bcdc_pkg::BCDC_BYP_INT_LOW || mode == bcdc_pkg::BCDC_BYP_EXT_LOW
                         || mode == bcdc_pkg::BCDC_STOP);

  // pick the selected edge; stop mode gives no bus clock
  always_comb begin
    case (clock_source_select)
      bcdc_pkg::CSRC_INT: src_tick = int_ref_tick;
      bcdc_pkg::CSRC_EXT: src_tick = ext_ref_tick;
      default:            src_tick = loop_tick && loop_enable;
    endcase
  end

  bcdc_bus_div u_div (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .src_tick (src_tick),
    .div_code (ctrl_two[bcdc_pkg::DIV_HI:bcdc_pkg::DIV_LO]),
    .bus_tick (bus_tick)
  );

  // oscillator controls straight from the control bits
  assign osc_high_range = ctrl_two[bcdc_pkg::RANGE_B];
  assign osc_high_gain  = ctrl_two[bcdc_pkg::GAIN_B];
  // the reference is in use by the enable bit or by an external mode
  assign ext_sel = ctrl_two[bcdc_pkg::ERCLK_B] || mode == bcdc_pkg::BCDC_ENG_EXT
                   || mode == bcdc_pkg::BCDC_BYP_EXT || mode == bcdc_pkg::BCDC_BYP_EXT_LOW;
  assign osc_request = ctrl_two[bcdc_pkg::EREF_B] && ext_sel;

  // drop on a write that clears a set enable or select bit
  assign drop = wr_stb && wb_adr_i == bcdc_pkg::OFS_CTRL_TWO
                && ((ctrl_two[bcdc_pkg::ERCLK_B] && !wb_dat_i[bcdc_pkg::ERCLK_B])
                 || (ctrl_two[bcdc_pkg::EREF_B] && !wb_dat_i[bcdc_pkg::EREF_B]));

  bcdc_osc_init #(
    .STARTUP (OSC_STARTUP)
  ) u_osc (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .osc_tick (ext_ref_tick),
    .run      (osc_request),
    .drop     (drop),
    .ready    (osc_ready)
  );

  // reference output; crystal edges only count once it is ready
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_ref_clock_out <= 1'b0;
    end else begin
      ext_ref_clock_out <= ctrl_two[bcdc_pkg::ERCLK_B] && ext_ref_tick
                           && (osc_ready || !ctrl_two[bcdc_pkg::EREF_B]);
    end
  end

  // sticky events; a new event wins over a read in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      osc_ready_d <= 1'b0;
      irq_status  <= '0;
    end else begin
      osc_ready_d <= osc_ready;
      if (rd_stb && wb_adr_i == bcdc_pkg::OFS_IRQ_STATUS) begin
        irq_status <= '0;
      end
      if (osc_ready && !osc_ready_d) irq_status[bcdc_pkg::EV_OSCRDY] <= 1'b1;
      if (next_mode != mode) irq_status[bcdc_pkg::EV_MODE] <= 1'b1;
    end
  end
  assign irq = |(irq_status & irq_mask);

  // read data registered; unmapped reads give zero; ready is read-only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (rd_stb) begin
      case (wb_adr_i)
        bcdc_pkg::OFS_CTRL_TWO:    wb_dat_o <= {24'h000000, ctrl_two};
        bcdc_pkg::OFS_STATUS_TRIM: wb_dat_o <= {30'h00000000, osc_ready, fine_trim_bit};
        bcdc_pkg::OFS_MODE_REQ:    wb_dat_o <= {25'h0000000, mode, 2'h0, mode_req};
        bcdc_pkg::OFS_IRQ_STATUS:  wb_dat_o <= {30'h00000000, irq_status};
        bcdc_pkg::OFS_IRQ_MASK:    wb_dat_o <= {30'h00000000, irq_mask};
        default:                   wb_dat_o <= '0;
      endcase
    end
  end

  // checks
  chk_div_reset: assert property (@(posedge clk_sys) $rose(rst_n) |->
    ctrl_two[7:6] == 2'h1) else $error("divider not two after reset");
  chk_mode_reset: assert property (@(posedge clk_sys) $rose(rst_n) && !stop_req |->
    mode == bcdc_pkg::BCDC_ENG_INT) else $error("mode not engaged internal after reset");
  chk_range_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osc_high_range == ctrl_two[5] && osc_high_gain == ctrl_two[4])
    else $error("range or gain pin wrong");
  chk_gain_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_stb && wb_adr_i == 8'h00 |=> osc_high_gain == $past(wb_dat_i[4]))
    else $error("gain not from write");
  chk_loop_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mode == bcdc_pkg::BCDC_BYP_INT_LOW || mode == bcdc_pkg::BCDC_BYP_EXT_LOW) |->
    !loop_enable && $past(lowpwr_ok)) else $error("loop runs in low power");
  chk_osc_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl_two[2] |-> !osc_request) else $error("oscillator requested without select");
  chk_ref_out: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ctrl_two[1] |=> !ext_ref_clock_out) else $error("reference out while off");
  chk_ready_fall: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(osc_ready) |-> $past(drop)) else $error("ready fell without drop");
  chk_ready_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(osc_ready) |-> $past(osc_request) && $past(ext_ref_tick))
    else $error("ready rose without request");
  chk_trim_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_stb && wb_adr_i == 8'h04 |=> fine_trim_bit == $past(wb_dat_i[0]) && $stable(osc_ready))
    else $error("trim write wrong or ready changed");
  chk_bus_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bus_tick |-> $past(src_tick)) else $error("bus tick without source edge");

  // divider and range bits land exactly as written
  chk_div_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_stb && wb_adr_i == bcdc_pkg::OFS_CTRL_TWO |=> ctrl_two[7:6] == $past(wb_dat_i[7:6]))
    else $error("divider not from write");
  chk_range_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_stb && wb_adr_i == bcdc_pkg::OFS_CTRL_TWO |=> osc_high_range == $past(wb_dat_i[5]))
    else $error("range not from write");

  // bypass external modes run the bus from the external reference
  chk_src_ext: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == bcdc_pkg::BCDC_BYP_EXT || mode == bcdc_pkg::BCDC_BYP_EXT_LOW |->
    clock_source_select == bcdc_pkg::CSRC_EXT) else $error("bypass source wrong");

  // engaged modes keep the loop running; debug leaves low power at once
  chk_loop_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == bcdc_pkg::BCDC_ENG_INT || mode == bcdc_pkg::BCDC_ENG_EXT |-> loop_enable)
    else $error("loop off while engaged");
  chk_debug_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    background_debug_mode |=>
    !(mode == bcdc_pkg::BCDC_BYP_INT_LOW || mode == bcdc_pkg::BCDC_BYP_EXT_LOW))
    else $error("low power kept under debug");

  // ready only falls on a drop; trim only changes on its write
  chk_ready_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    osc_ready && !drop |=> osc_ready) else $error("ready lost without drop");
  chk_trim_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(wr_stb && wb_adr_i == bcdc_pkg::OFS_STATUS_TRIM) |=> $stable(fine_trim_bit))
    else $error("trim changed without write");

  // stop is entered the cycle after it is asked; no unused code appears
  chk_stop_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    stop_req |=> mode == bcdc_pkg::BCDC_STOP) else $error("stop not entered");
  chk_mode_legal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode != 3'h4) else $error("illegal mode code");

  // bus handshake: one answer per taken request, one cycle long
  chk_ack_next: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
  chk_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("answer held too long");

  // a mode event stays until its register is read
  chk_event_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_status[bcdc_pkg::EV_MODE] && !(rd_stb && wb_adr_i == bcdc_pkg::OFS_IRQ_STATUS)
    |=> irq_status[bcdc_pkg::EV_MODE]) else $error("mode event lost");
endmodule
`default_nettype wire

// file: core/bcdc_pkg.sv
// bcdc_pkg: register map, field positions, reset values and mode codes
// of the bus clock divider and external reference control block.
// assumes a 32-bit classic wishbone slave with one register per word.
package bcdc_pkg;

  // byte offsets of the registers
  localparam logic [7:0] OFS_CTRL_TWO    = 8'h00; // clock_control_two
  localparam logic [7:0] OFS_STATUS_TRIM = 8'h04; // clock_status_trim
  localparam logic [7:0] OFS_MODE_REQ    = 8'h08; // requested operating mode
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h0C; // sticky events, read clears
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h10; // event mask

  // clock_control_two field positions
  localparam int DIV_HI   = 7; // bus_divider_field msb
  localparam int DIV_LO   = 6; // bus_divider_field lsb
  localparam int RANGE_B  = 5; // high frequency range
  localparam int GAIN_B   = 4; // high_gain_select
  localparam int LOWPWR_B = 3; // low_power_select
  localparam int EREF_B   = 2; // ext_ref_select
  localparam int ERCLK_B  = 1; // ext_ref_output_enable

  // clock_status_trim field positions
  localparam int OSCRDY_B = 1; // oscillator_ready_flag
  localparam int TRIM_B   = 0; // fine_trim_bit

  // irq status / mask bits
  localparam int EV_OSCRDY = 0; // oscillator became ready
  localparam int EV_MODE   = 1; // operating mode changed
  localparam int EV_W      = 2; // event count

  // reset values
  localparam logic [7:0] RST_CTRL_TWO = 8'h40; // divide by two
  localparam logic [1:0] RST_MODE_REQ = 2'h0;  // engaged internal
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // mode request codes (full power modes only)
  localparam logic [1:0] REQ_ENG_INT = 2'h0;
  localparam logic [1:0] REQ_ENG_EXT = 2'h1;
  localparam logic [1:0] REQ_BYP_INT = 2'h2;
  localparam logic [1:0] REQ_BYP_EXT = 2'h3;

  // clock source select codes
  localparam logic [1:0] CSRC_LOOP = 2'h0; // loop output
  localparam logic [1:0] CSRC_INT  = 2'h1; // internal reference
  localparam logic [1:0] CSRC_EXT  = 2'h2; // external reference

  // oscillator start-up cycles (arbitrary plain default)
  localparam int OSC_STARTUP_CYCLES = 4096;

  // seven operating modes, gray codes along the usual path
  typedef enum logic [2:0] {
    BCDC_ENG_INT     = 3'h0, // loop_engaged_internal_mode
    BCDC_ENG_EXT     = 3'h1, // loop_engaged_external_mode
    BCDC_BYP_EXT     = 3'h3, // loop_bypassed_external_mode
    BCDC_BYP_EXT_LOW = 3'h2, // bypassed_external_low_power_mode
    BCDC_BYP_INT     = 3'h6, // loop bypassed internal
    BCDC_BYP_INT_LOW = 3'h7, // bypassed internal low power
    BCDC_STOP  = 3'h5  // stopped
  } bcdc_mode_t;

endpackage

// file: core/bcdc_bus_div.sv
// bcdc_bus_div: divides ticks of the selected clock by 1, 2, 4 or 8.
// assumes src_tick is a one-cycle pulse per selected clock period.
`timescale 1ns/1ps
`default_nettype none
module bcdc_bus_div #(
  parameter int CNT_W = 3 // counter width, enough for divide by 8
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       src_tick,  // selected clock edge
  input  wire logic [1:0] div_code,  // bus_divider_field
  output logic            bus_tick   // one pulse per bus clock
);
  initial begin
    if (CNT_W < 3) $error("bcdc_bus_div: CNT_W below 3");
  end

  logic [CNT_W-1:0] cnt;      // ticks seen in this bus period
  logic [CNT_W-1:0] last_cnt; // terminal count for the code

  // 00 by 1, 01 by 2, 10 by 4, 11 by 8
  always_comb begin
    last_cnt = CNT_W'((1 << div_code) - 1);
  end

  // count source ticks; a code change applies at once, a count past the new end wraps on the next tick
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt      <= '0;
      bus_tick <= 1'b0;
    end else begin
      bus_tick <= 1'b0;
      if (src_tick) begin
        if (cnt >= last_cnt) begin
          cnt      <= '0;
          bus_tick <= 1'b1;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: core/bcdc_osc_init.sv
// bcdc_osc_init: counts oscillator start-up cycles and holds the ready flag.
// assumes osc_tick pulses once per oscillator cycle while it runs.
`timescale 1ns/1ps
`default_nettype none
module bcdc_osc_init #(
  parameter int STARTUP = bcdc_pkg::OSC_STARTUP_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic osc_tick,  // oscillator cycle
  input  wire logic run,       // oscillator requested and selected
  input  wire logic drop,      // enable or select bit just cleared
  output logic      ready      // oscillator_ready_flag
);
  localparam int CW = $clog2(STARTUP + 1);
  initial begin
    if (STARTUP < 1) $error("bcdc_osc_init: STARTUP below 1");
  end

  logic [CW-1:0] cnt; // start-up cycles seen

  // the flag only ever falls on a drop; leaving the mode alone keeps it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt   <= '0;
      ready <= 1'b0;
    end else if (drop) begin
      cnt   <= '0;
      ready <= 1'b0;
    end else if (run && !ready && osc_tick) begin
      if (cnt == CW'(STARTUP - 1)) begin
        ready <= 1'b1;
      end
      cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: test/bcdc_osc_model.sv
// bcdc_osc_model: external crystal or clock source on the far side.
// assumes one system clock; each tick stands for one edge of the outside clock.
`timescale 1ns/1ps
`default_nettype none
module bcdc_osc_model (
  input  wire logic clk_sys,      // system clock
  input  wire logic osc_request,  // oscillator asked to run
  input  wire logic slow,         // one edge every fourth cycle
  output logic      ext_ref_tick  // one pulse per outside edge
);
  int unsigned gap; // cycles since the last edge
  initial begin
    ext_ref_tick = 1'b0;
    gap = 0;
  end
  // a stopped oscillator gives no edges from the cycle after the request falls; one registered pulse can still leak out
  always @(posedge clk_sys) begin
    gap <= (gap >= 3) ? 0 : gap + 1;
    ext_ref_tick <= osc_request && (!slow || gap == 0);
  end
endmodule
`default_nettype wire

// file: test/bus_clock_divider_ext_ref_control_tb.sv
// bus_clock_divider_ext_ref_control_tb: self-checking bench of bcdc_top.
// assumes the wishbone timing and register map of the designer's note.
`timescale 1ns/1ps
`default_nettype none
module bus_clock_divider_ext_ref_control_tb;
  localparam int         STARTUP = 4; // short start-up keeps the run brief
  localparam logic [7:0] A_CTRL  = bcdc_pkg::OFS_CTRL_TWO;
  localparam logic [7:0] A_STAT  = bcdc_pkg::OFS_STATUS_TRIM;
  localparam logic [7:0] A_MODE  = bcdc_pkg::OFS_MODE_REQ;
  localparam logic [7:0] A_IRQ   = bcdc_pkg::OFS_IRQ_STATUS;
  localparam logic [7:0] A_MASK  = bcdc_pkg::OFS_IRQ_MASK;
  logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [3:0]  wb_sel_i;
  logic        loop_tick, int_ref_tick, ext_ref_tick, background_debug_mode, stop_req, slow;
  logic        bus_tick, ext_ref_clock_out, osc_request, osc_high_range, osc_high_gain;
  logic        loop_enable, fine_trim_bit, irq, prev;
  logic [1:0]  clock_source_select;
  logic [2:0]  mode_state;
  logic [2:0]  mode_tbl [4];  // expected mode for each request code
  int          n_mismatch, cmp_count, cycles, seed, exp_ctrl, cnt;

  bcdc_top #(.OSC_STARTUP(STARTUP)) i_dut (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .loop_tick, .int_ref_tick,
    .ext_ref_tick, .background_debug_mode, .stop_req, .bus_tick, .ext_ref_clock_out,
    .osc_request, .osc_high_range, .osc_high_gain, .loop_enable, .fine_trim_bit,
    .clock_source_select, .mode_state, .irq);
  bcdc_osc_model i_osc (.clk_sys, .osc_request, .slow, .ext_ref_tick);

  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    int_ref_tick <= $random(seed); // random internal edges, selected only in the bypass internal request step, where bus ticks go unchecked
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    // no assumed latency: only the hang guard ends this wait
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, 4'hF, q);
    @(posedge clk_sys); // let combinational outputs of the new value settle
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(a, 1'b0, 32'h00000000, 4'hF, q);
    compare(q, exp);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, background_debug_mode, stop_req, slow} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, int_ref_tick} = '0;
    loop_tick = 1'b1; // selected clock ticks every cycle, so counts are exact
    {n_mismatch, cmp_count, cycles} = '0;
    seed = 32'h7377E1E9;
    mode_tbl = '{bcdc_pkg::BCDC_ENG_INT, bcdc_pkg::BCDC_ENG_EXT, bcdc_pkg::BCDC_BYP_INT,
                 bcdc_pkg::BCDC_BYP_EXT};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset state
    rd_chk(A_CTRL, 32'h40);
    rd_chk(A_STAT, 32'h0);
    compare(mode_state, bcdc_pkg::BCDC_ENG_INT);
    compare(loop_enable, 1'b1);
    // every divider code, random range and gain bits alongside
    for (int c = 0; c < 4; c++) begin
      exp_ctrl = {c[1:0], 6'h00} | ($random(seed) & 32'h30);
      wr(A_CTRL, exp_ctrl | 32'h1); // bit 0 is read-only and reads back 0
      rd_chk(A_CTRL, exp_ctrl);
      compare(osc_high_range, exp_ctrl[5]);
      compare(osc_high_gain, exp_ctrl[4]);
      compare(clock_source_select, bcdc_pkg::CSRC_LOOP);
      repeat (16) @(posedge clk_sys);
      cnt = 0;
      repeat (64) begin
        @(posedge clk_sys);
        cnt += bus_tick;
      end
      compare(cnt, 64 >> c);
    end
    // refused accesses: byte lane 0 off, unmapped place
    wb_xfer(A_CTRL, 1'b1, 32'hFF, 4'hE, rdat);
    rd_chk(A_CTRL, exp_ctrl);
    rd_chk(8'h20, 32'h0);
    // crystal requested and output on, slow oscillator
    slow <= 1'b1;
    wr(A_CTRL, 32'h46);
    compare(osc_request, 1'b1);
    rd_chk(A_STAT, 32'h0);
    cnt = 0;
    for (int i = 0; i < 100 && cnt < STARTUP; i++) begin
      @(posedge clk_sys);
      cnt += ext_ref_tick;
    end
    repeat (2) @(posedge clk_sys);
    rd_chk(A_STAT, 32'h2);
    compare(irq, 1'b0); // masked event raises nothing
    wr(A_MASK, 32'h1);
    compare(irq, 1'b1);
    rd_chk(A_IRQ, 32'h1);
    @(posedge clk_sys);
    compare(irq, 1'b0); // read cleared the sticky bit
    // software cannot touch the ready flag; trim bit is plain storage
    wr(A_STAT, 32'h1);
    rd_chk(A_STAT, 32'h3);
    compare(fine_trim_bit, 1'b1);
    wr(A_STAT, 32'h0);
    compare(fine_trim_bit, 1'b0);
    // output follows the outside edges one cycle late
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (i > 0) compare(ext_ref_clock_out, prev);
      prev = ext_ref_tick;
    end
    wr(A_CTRL, 32'h86); // divider change alone keeps ready
    rd_chk(A_STAT, 32'h2);
    wr(A_CTRL, 32'h84); // enable cleared
    rd_chk(A_STAT, 32'h0);
    compare(ext_ref_clock_out, 1'b0);
    // all request codes with low power off
    wr(A_CTRL, 32'h40);
    for (int i = 0; i < 4; i++) begin
      wr(A_MODE, i);
      repeat (3) @(posedge clk_sys);
      compare(mode_state, mode_tbl[i]);
      compare(loop_enable, 1'b1);
    end
    // low power in bypass: held off by debug, taken once debug ends
    background_debug_mode <= 1'b1;
    wr(A_CTRL, 32'h48);
    repeat (3) @(posedge clk_sys);
    compare(mode_state, bcdc_pkg::BCDC_BYP_EXT);
    compare(loop_enable, 1'b1);
    background_debug_mode <= 1'b0;
    repeat (3) @(posedge clk_sys);
    compare(mode_state, bcdc_pkg::BCDC_BYP_EXT_LOW);
    compare(loop_enable, 1'b0);
    compare(clock_source_select, bcdc_pkg::CSRC_EXT);
    rd_chk(A_MODE, 32'h23);
    wr(A_MODE, bcdc_pkg::REQ_ENG_INT);
    repeat (4) @(posedge clk_sys);
    compare(mode_state, bcdc_pkg::BCDC_ENG_INT);
    rd_chk(A_IRQ, 32'h2);
    // stop and back, mode event unmasked
    wr(A_MASK, 32'h3);
    stop_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    compare(mode_state, bcdc_pkg::BCDC_STOP);
    compare(irq, 1'b1);
    stop_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
    compare(mode_state, bcdc_pkg::BCDC_ENG_INT);
    wrap_up();
  end
endmodule
`default_nettype wire
